/* File: rtl/flic_pkg.sv */
// package for the four-level interrupt controller: source indices, bit positions, vectors, ranking
// assumes nothing beyond a SystemVerilog compiler
package flic_pkg;
  localparam int NSRC = 9;
  // source index equals arbitration rank, 0 = first
  localparam int SRC_EXT0 = 0;
  localparam int SRC_BROWNOUT = 1;
  localparam int SRC_WATCHDOG = 2;
  localparam int SRC_TIMER0 = 3;
  localparam int SRC_TWO_WIRE = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_KEYPAD = 6;
  localparam int SRC_TIMER1 = 7;
  localparam int SRC_SERIAL = 8;
  // enable bit positions, main register
  localparam int MAIN_EXT0_BIT = 0;
  localparam int MAIN_TIMER0_BIT = 1;
  localparam int MAIN_EXT1_BIT = 2;
  localparam int MAIN_TIMER1_BIT = 3;
  localparam int MAIN_SERIAL_BIT = 4;
  localparam int MAIN_GLOBAL_BIT = 7;
  // enable bit positions, extended register
  localparam int EXT_TWO_WIRE_BIT = 0;
  localparam int EXT_KEYPAD_BIT = 1;
  localparam int EXT_WATCHDOG_BIT = 4;
  localparam int EXT_BROWNOUT_BIT = 6;
  // priority bits share the same positions in group0 (main) and group1 (extended) registers
  typedef logic [15:0] flic_vec_t;
  localparam flic_vec_t VEC_EXT0 = 16'h0003;
  localparam flic_vec_t VEC_TIMER0 = 16'h000b;
  localparam flic_vec_t VEC_EXT1 = 16'h0013;
  localparam flic_vec_t VEC_TIMER1 = 16'h001b;
  localparam flic_vec_t VEC_SERIAL = 16'h0023;
  localparam flic_vec_t VEC_BROWNOUT = 16'h002b;
  localparam flic_vec_t VEC_TWO_WIRE = 16'h0033;
  localparam flic_vec_t VEC_KEYPAD = 16'h003b;
  localparam flic_vec_t VEC_WATCHDOG = 16'h0053;
  localparam logic [8:0] WAKE_MASK = 9'h067; // ext0 brownout watchdog ext1 keypad
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam logic [3:0] ACT_RESET = 4'h0;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [15:0] VEC_RESET = 16'h0000;
endpackage : flic_pkg

/* File: rtl/flic_req_if.sv */
// request bundle between the arbiter and the controller top
// assumes flic_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none
interface flic_req_if;
  import flic_pkg::*;
  logic [NSRC-1:0] req;
  logic [NSRC*2-1:0] lvl;
  logic found;
  logic [3:0] win_idx;
  logic [1:0] win_lvl;
  modport arb (input req, input lvl, output found, output win_idx, output win_lvl);
  modport top (output req, output lvl, input found, input win_idx, input win_lvl);
endinterface : flic_req_if
`default_nettype wire

/* File: rtl/flic_arbiter.sv */
// arbiter: highest level first, fixed rank (lowest index) breaks ties
// assumes index order of the request vector is arbitration rank
`timescale 1ns/1ps
`default_nettype none
module flic_arbiter (
  flic_req_if.arb rq // requests in, winner out
);
  import flic_pkg::*;
  always_comb begin
    rq.found = 1'b0;
    rq.win_idx = 4'h0;
    rq.win_lvl = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      // strictly greater keeps the earlier rank on a level tie
      if (rq.req[i] && (!rq.found || rq.lvl[2*i +: 2] > rq.win_lvl)) begin // RQ7 RQ8 RQ9
        rq.found = 1'b1;
        rq.win_idx = 4'(i);
        rq.win_lvl = rq.lvl[2*i +: 2];
      end
    end
  end
endmodule : flic_arbiter
`default_nettype wire

/* File: rtl/flic_edge_det.sv */
// external pin edge/level flag: two-flop sync, falling-edge detect per machine cycle
// assumes mc_tick marks one machine-cycle sample point
`timescale 1ns/1ps
`default_nettype none
module flic_edge_det (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, low
  input wire logic pin_n, // external request pin
  input wire logic mc_tick, // machine-cycle sample strobe
  input wire logic edge_mode, // 1 edge, 0 level
  input wire logic vec_clr, // vectored to this source
  input wire logic sw_clr, // software clear
  output logic flag // request flag
);
  import flic_pkg::*;
  logic [1:0] sync_q;
  logic smp_q;
  logic flag_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= SYNC_RESET;
    end else begin
      sync_q <= {sync_q[0], pin_n};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_q <= 1'b1;
    end else if (mc_tick) begin
      smp_q <= sync_q[1];
    end
  end
  // set beats any clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (!edge_mode) begin
      flag_q <= !sync_q[1]; // RQ13
    end else if (mc_tick && smp_q && !sync_q[1]) begin
      flag_q <= 1'b1; // RQ13
    end else if (vec_clr || sw_clr) begin
      flag_q <= 1'b0; // RQ13
    end
  end
  assign flag = flag_q;
endmodule : flic_edge_det
`default_nettype wire

/* File: rtl/flic_top.sv */
// four-level interrupt controller for an 8-bit core
// assumes the core sequencer gives machine-cycle, last-cycle, reti and register-write strobes on clk
// Summary of operation
// RQ1: each source has a high and low priority bit forming levels 0 to 3.
// RQ2: per-source enable bits sit in main and extended enable registers.
// RQ3: cleared global enable blocks every source.
// RQ4: priority bits share source bit positions across the four priority registers.
// RQ5: active routine is preempted only by a strictly higher level request.
// RQ6: a level 3 routine is never preempted.
// RQ7: simultaneous requests at different levels: highest level wins.
// RQ8: same level ties resolved by fixed rank ext0 first through serial last.
// RQ9: ranking never overrides a level difference.
// RQ10: each source vectors to its own fixed address.
// RQ11: brownout and timer/ext flags cleared by hardware; others by software. Here ext flags are hardware-cleared only in edge mode.
// RQ12: ext0, ext1, brownout, watchdog, keypad may wake from power-down.
// RQ13: edge mode samples each machine cycle, sets on high-then-low, clears on vectoring.
// RQ14: vector only when no equal or higher level active, last cycle, no blocking instruction.
// RQ15: pending requests are not latched; every poll is fresh.
// RQ16: in-service state ends only on return-from-interrupt.
// RQ17: a source requests only when flag, own enable and global enable are set.
`timescale 1ns/1ps
`default_nettype none
module flic_top (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, low
  input wire logic mc_tick, // one pulse per machine cycle (poll point)
  input wire logic last_cycle, // poll is in the last machine cycle of the instruction
  input wire logic instr_reti, // current instruction is return-from-interrupt
  input wire logic instr_wr_irq_reg, // current instruction writes an enable or priority register
  input wire logic ext0_pin_n, // external request 0 pin
  input wire logic ext1_pin_n, // external request 1 pin
  input wire logic ext0_edge_mode, // ext0 edge mode
  input wire logic ext1_edge_mode, // ext1 edge mode
  input wire logic ext0_sw_clr, // software clears ext0 flag
  input wire logic ext1_sw_clr, // software clears ext1 flag
  input wire logic brownout_flag, // brownout request
  input wire logic watchdog_flag, // watchdog request
  input wire logic timer0_overflow_flag, // timer0 request
  input wire logic timer1_overflow_flag, // timer1 request
  input wire logic two_wire_status_flag, // two-wire new state
  input wire logic two_wire_timeout_flag, // two-wire timeout
  input wire logic keypad_flag, // keypad request
  input wire logic serial_rx_flag, // serial receive
  input wire logic serial_tx_flag, // serial transmit
  input wire logic [7:0] main_enable_reg, // main enable register
  input wire logic [7:0] extended_enable_reg, // extended enable register
  input wire logic [7:0] prio_low_group0, // low priority bits, main group
  input wire logic [7:0] prio_high_group0, // high priority bits, main group
  input wire logic [7:0] prio_low_group1, // low priority bits, extended group
  input wire logic [7:0] prio_high_group1, // high priority bits, extended group
  output logic vec_call, // vector request to the core, one-cycle pulse
  output logic [15:0] vec_addr, // vector address, registered
  output logic ext0_flag, // ext0 request flag
  output logic ext1_flag, // ext1 request flag
  output logic clr_ext0, // hardware clear to ext0 source
  output logic clr_timer0, // hardware clear to timer0
  output logic clr_timer1, // hardware clear to timer1
  output logic clr_brownout, // hardware clear to brownout
  output logic wake_req, // power-down wake request
  output logic [3:0] active_levels, // in-service levels, registered
  output logic clr_ext1 // hardware clear to ext1 source
);
  import flic_pkg::*;
  function automatic flic_vec_t vec_of(input logic [3:0] idx);
    case (idx)
      4'(SRC_EXT0): vec_of = VEC_EXT0;
      4'(SRC_BROWNOUT): vec_of = VEC_BROWNOUT;
      4'(SRC_WATCHDOG): vec_of = VEC_WATCHDOG;
      4'(SRC_TIMER0): vec_of = VEC_TIMER0;
      4'(SRC_TWO_WIRE): vec_of = VEC_TWO_WIRE;
      4'(SRC_EXT1): vec_of = VEC_EXT1;
      4'(SRC_KEYPAD): vec_of = VEC_KEYPAD;
      4'(SRC_TIMER1): vec_of = VEC_TIMER1;
      default: vec_of = VEC_SERIAL;
    endcase
  endfunction : vec_of
  function automatic logic [1:0] top_level(input logic [3:0] act);
    top_level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        top_level = 2'(l);
      end
    end
  endfunction : top_level

  flic_req_if rq ();
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] enables;
  logic [NSRC-1:0] hi_bits;
  logic [NSRC-1:0] lo_bits;
  logic [3:0] active_q;
  logic [3:0] active_d;
  logic vec_q;
  flic_vec_t addr_q;
  logic [NSRC-1:0] clr_q;
  logic ok_level;
  logic take;
  logic global_en;
  logic [1:0] cur_lvl;

  flic_edge_det u_ext0 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_n(ext0_pin_n),
    .mc_tick(mc_tick),
    .edge_mode(ext0_edge_mode),
    .vec_clr(clr_q[SRC_EXT0]),
    .sw_clr(ext0_sw_clr),
    .flag(ext0_flag)
  );
  flic_edge_det u_ext1 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_n(ext1_pin_n),
    .mc_tick(mc_tick),
    .edge_mode(ext1_edge_mode),
    .vec_clr(clr_q[SRC_EXT1]),
    .sw_clr(ext1_sw_clr),
    .flag(ext1_flag)
  );

  assign flags[SRC_EXT0] = ext0_flag;
  assign flags[SRC_BROWNOUT] = brownout_flag;
  assign flags[SRC_WATCHDOG] = watchdog_flag;
  assign flags[SRC_TIMER0] = timer0_overflow_flag;
  assign flags[SRC_TWO_WIRE] = two_wire_status_flag | two_wire_timeout_flag; // RQ11
  assign flags[SRC_EXT1] = ext1_flag;
  assign flags[SRC_KEYPAD] = keypad_flag;
  assign flags[SRC_TIMER1] = timer1_overflow_flag;
  assign flags[SRC_SERIAL] = serial_rx_flag | serial_tx_flag; // RQ11

  assign enables[SRC_EXT0] = main_enable_reg[MAIN_EXT0_BIT]; // RQ2
  assign enables[SRC_TIMER0] = main_enable_reg[MAIN_TIMER0_BIT]; // RQ2
  assign enables[SRC_EXT1] = main_enable_reg[MAIN_EXT1_BIT]; // RQ2
  assign enables[SRC_TIMER1] = main_enable_reg[MAIN_TIMER1_BIT]; // RQ2
  assign enables[SRC_SERIAL] = main_enable_reg[MAIN_SERIAL_BIT]; // RQ2
  assign enables[SRC_TWO_WIRE] = extended_enable_reg[EXT_TWO_WIRE_BIT]; // RQ2
  assign enables[SRC_KEYPAD] = extended_enable_reg[EXT_KEYPAD_BIT]; // RQ2
  assign enables[SRC_WATCHDOG] = extended_enable_reg[EXT_WATCHDOG_BIT]; // RQ2
  assign enables[SRC_BROWNOUT] = extended_enable_reg[EXT_BROWNOUT_BIT]; // RQ2

  // priority bits at the source's own enable position in the matching group
  assign hi_bits[SRC_EXT0] = prio_high_group0[MAIN_EXT0_BIT]; // RQ4
  assign lo_bits[SRC_EXT0] = prio_low_group0[MAIN_EXT0_BIT]; // RQ4
  assign hi_bits[SRC_TIMER0] = prio_high_group0[MAIN_TIMER0_BIT];
  assign lo_bits[SRC_TIMER0] = prio_low_group0[MAIN_TIMER0_BIT];
  assign hi_bits[SRC_EXT1] = prio_high_group0[MAIN_EXT1_BIT];
  assign lo_bits[SRC_EXT1] = prio_low_group0[MAIN_EXT1_BIT];
  assign hi_bits[SRC_TIMER1] = prio_high_group0[MAIN_TIMER1_BIT];
  assign lo_bits[SRC_TIMER1] = prio_low_group0[MAIN_TIMER1_BIT];
  assign hi_bits[SRC_SERIAL] = prio_high_group0[MAIN_SERIAL_BIT];
  assign lo_bits[SRC_SERIAL] = prio_low_group0[MAIN_SERIAL_BIT];
  assign hi_bits[SRC_TWO_WIRE] = prio_high_group1[EXT_TWO_WIRE_BIT];
  assign lo_bits[SRC_TWO_WIRE] = prio_low_group1[EXT_TWO_WIRE_BIT];
  assign hi_bits[SRC_KEYPAD] = prio_high_group1[EXT_KEYPAD_BIT];
  assign lo_bits[SRC_KEYPAD] = prio_low_group1[EXT_KEYPAD_BIT];
  assign hi_bits[SRC_WATCHDOG] = prio_high_group1[EXT_WATCHDOG_BIT];
  assign lo_bits[SRC_WATCHDOG] = prio_low_group1[EXT_WATCHDOG_BIT];
  assign hi_bits[SRC_BROWNOUT] = prio_high_group1[EXT_BROWNOUT_BIT]; // RQ4
  assign lo_bits[SRC_BROWNOUT] = prio_low_group1[EXT_BROWNOUT_BIT];

  assign global_en = main_enable_reg[MAIN_GLOBAL_BIT];
  assign rq.req = flags & enables & {NSRC{global_en}}; // RQ3 RQ17
  always_comb begin
    rq.lvl = '0;
    for (int i = 0; i < NSRC; i++) begin
      rq.lvl[2*i +: 2] = {hi_bits[i], lo_bits[i]}; // RQ1
    end
  end

  flic_arbiter u_arb (
    .rq(rq)
  );

  assign cur_lvl = top_level(active_q);
  // strictly above the highest in-service level; nothing beats level 3
  assign ok_level = (active_q == ACT_RESET) ||
                    (cur_lvl != LVL_TOP && rq.win_lvl > cur_lvl); // RQ5 RQ6
  // decided fresh from live requests at each poll, nothing held over
  assign take = mc_tick && rq.found && ok_level && last_cycle &&
                !instr_wr_irq_reg && !instr_reti; // RQ14 RQ15 RQ17

  always_comb begin
    active_d = active_q;
    if (mc_tick && instr_reti && active_q != ACT_RESET) begin
      active_d[cur_lvl] = 1'b0; // RQ16
    end
    if (take) begin
      active_d[rq.win_lvl] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= ACT_RESET;
    end else begin
      active_q <= active_d; // RQ16
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_q <= 1'b0;
      addr_q <= VEC_RESET;
    end else begin
      vec_q <= take;
      if (take) begin
        addr_q <= vec_of(rq.win_idx); // RQ10
      end
    end
  end

  // hardware clears: ext (edge only, inside the detector), timers, brownout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_q <= '0;
    end else begin
      clr_q <= '0;
      if (take) begin
        clr_q[rq.win_idx] <= 1'b1; // RQ11
      end
    end
  end

  assign vec_call = vec_q;
  assign vec_addr = addr_q;
  assign active_levels = active_q;
  assign clr_ext0 = clr_q[SRC_EXT0] & ext0_edge_mode; // RQ13
  assign clr_ext1 = clr_q[SRC_EXT1] & ext1_edge_mode; // RQ13
  assign clr_timer0 = clr_q[SRC_TIMER0]; // RQ11
  assign clr_timer1 = clr_q[SRC_TIMER1]; // RQ11
  assign clr_brownout = clr_q[SRC_BROWNOUT]; // RQ11
  assign wake_req = |(flags & enables & WAKE_MASK); // RQ12

  // recount of each poll apart from the arbiter: requests that should have beaten the winner
  logic [NSRC-1:0] beat_lvl;
  logic [NSRC-1:0] beat_rank;
  always_comb begin
    beat_lvl = '0;
    beat_rank = '0;
    for (int i = 0; i < NSRC; i++) begin
      beat_lvl[i] = rq.req[i] && ({hi_bits[i], lo_bits[i]} > rq.win_lvl);
      beat_rank[i] = rq.req[i] && ({hi_bits[i], lo_bits[i]} == rq.win_lvl) && (4'(i) < rq.win_idx);
    end
  end

  level_order_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
    take |-> (active_q == ACT_RESET || rq.win_lvl > cur_lvl))
    else $error("vectored at or below active level");
  top_level_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    active_q[3] |-> !take)
    else $error("level 3 routine preempted");
  global_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    !global_en |-> !take)
    else $error("vector with global enable off");
  vector_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
    take |=> vec_call && vec_addr == vec_of($past(rq.win_idx)))
    else $error("wrong vector address");
  poll_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
    (instr_reti || instr_wr_irq_reg || !last_cycle) |=> !vec_call)
    else $error("vector on blocked instruction");
  reti_only_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
    (|($past(active_q) & ~active_q)) |-> $past(mc_tick && instr_reti))
    else $error("in-service cleared without return");
  active_mark_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
    take |=> active_q[$past(rq.win_lvl)])
    else $error("active level not marked");
  rank_tie_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    (take && rq.req[SRC_EXT0] && rq.lvl[1:0] == rq.win_lvl) |-> rq.win_idx == 4'(SRC_EXT0))
    else $error("ext0 lost a tie");
  timer_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
    (take && rq.win_idx == 4'(SRC_TIMER0)) |=> clr_timer0 ##1 !clr_timer0)
    else $error("timer0 clear pulse wrong");
  wake_map_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
    wake_req |-> (ext0_flag && main_enable_reg[MAIN_EXT0_BIT]) ||
      (ext1_flag && main_enable_reg[MAIN_EXT1_BIT]) ||
      (brownout_flag && extended_enable_reg[EXT_BROWNOUT_BIT]) ||
      (watchdog_flag && extended_enable_reg[EXT_WATCHDOG_BIT]) ||
      (keypad_flag && extended_enable_reg[EXT_KEYPAD_BIT]))
    else $error("non-wake source woke");
  wake_source_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
    (brownout_flag && extended_enable_reg[EXT_BROWNOUT_BIT]) |-> wake_req)
    else $error("wake source did not wake");
  level_win_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ7 RQ9
    take |-> beat_lvl == '0)
    else $error("lower level beat a higher one");
  rank_win_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8 RQ9
    take |-> beat_rank == '0)
    else $error("later rank won a level tie");
  level_bits_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1 RQ4
    (take && rq.win_idx == 4'(SRC_BROWNOUT)) |->
      rq.win_lvl == {prio_high_group1[EXT_BROWNOUT_BIT], prio_low_group1[EXT_BROWNOUT_BIT]})
    else $error("brownout level bits misplaced");
  enable_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2 RQ17
    (take && rq.win_idx == 4'(SRC_WATCHDOG)) |-> watchdog_flag && extended_enable_reg[EXT_WATCHDOG_BIT])
    else $error("watchdog vectored while disabled");
  edge_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    (take && rq.win_idx == 4'(SRC_EXT0)) |=> clr_ext0 == ext0_edge_mode)
    else $error("ext0 clear does not follow mode");
  brownout_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
    (take && rq.win_idx == 4'(SRC_BROWNOUT)) |=> clr_brownout)
    else $error("brownout flag not cleared");
  poll_tick_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ14 RQ15
    !mc_tick |=> !vec_call)
    else $error("vector outside a poll");
  reti_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
    (mc_tick && instr_reti && active_q[3]) |=> !active_q[3])
    else $error("return left level 3 in service");
endmodule : flic_top
`default_nettype wire

/* File: bench/flic_core_model.sv */
// partner model: core sequencer that makes machine-cycle polls and instruction strobes
// assumes the bench drives its request inputs on the falling edge
`timescale 1ns/1ps
`default_nettype none
module flic_core_model (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, low
  input wire logic lc_en, // bench lets polls fall in last cycles
  input wire logic reti_go, // bench asks for a return-from-interrupt
  input wire logic wr_go, // bench asks for an enable or priority write
  output logic mc_tick, // poll strobe
  output logic last_cycle, // last machine cycle of the instruction
  output logic instr_reti, // return-from-interrupt in progress
  output logic instr_wr_irq_reg // register write in progress
);
  logic [1:0] cnt_q;
  // one poll every four clocks, launched off the falling edge
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  assign mc_tick = (cnt_q == 2'h3);
  assign last_cycle = lc_en;
  assign instr_reti = reti_go;
  assign instr_wr_irq_reg = wr_go;
endmodule : flic_core_model
`default_nettype wire

/* File: bench/four_level_interrupt_controller_tb.sv */
// self-checking bench for the four-level interrupt controller
// assumes flic_pkg, flic_req_if, the design modules and flic_core_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module four_level_interrupt_controller_tb;
  import flic_pkg::*;
  localparam logic [15:0] VEC_EXP [9] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033,
                                          16'h0013, 16'h003b, 16'h001b, 16'h0023};
  localparam logic [8:0] WAKE_EXP = 9'h067;
  localparam logic [8:0] CLR_EXP = 9'h08a; // ext sources in level mode here
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] flg = 9'h0, en = 9'h0, lo = 9'h0, hi = 9'h0, clr_seen;
  logic glob = 1'b0, edge_m = 1'b0, lc_en = 1'b1, reti_go = 1'b0, wr_go = 1'b0;
  logic sw_clr = 1'b0, tw_to = 1'b0, tx_f = 1'b0;
  logic mc_tick, last_cycle, instr_reti, instr_wr_irq_reg, vec_call, wake_req;
  logic ext0_flag, ext1_flag, clr_ext0, clr_ext1, clr_timer0, clr_timer1, clr_brownout;
  logic [15:0] vec_addr;
  logic [3:0] active_levels;
  int n_fail = 0, tests_run = 0, cyc = 0;
  function automatic logic [7:0] map0(input logic [8:0] v);
    return {3'h0, v[8], v[7], v[5], v[3], v[0]};
  endfunction : map0
  function automatic logic [7:0] map1(input logic [8:0] v);
    return {1'b0, v[1], 1'b0, v[2], 2'h0, v[6], v[4]};
  endfunction : map1
  flic_core_model core (.clk(clk), .rst_n(rst_n), .lc_en(lc_en), .reti_go(reti_go), .wr_go(wr_go),
    .mc_tick(mc_tick), .last_cycle(last_cycle), .instr_reti(instr_reti), .instr_wr_irq_reg(instr_wr_irq_reg));
  flic_top dut (.clk(clk), .rst_n(rst_n), .mc_tick(mc_tick), .last_cycle(last_cycle),
    .instr_reti(instr_reti), .instr_wr_irq_reg(instr_wr_irq_reg),
    .ext0_pin_n(~flg[0]), .ext1_pin_n(~flg[5]), .ext0_edge_mode(edge_m), .ext1_edge_mode(edge_m),
    .ext0_sw_clr(sw_clr), .ext1_sw_clr(sw_clr), .brownout_flag(flg[1]), .watchdog_flag(flg[2]),
    .timer0_overflow_flag(flg[3]), .timer1_overflow_flag(flg[7]), .two_wire_status_flag(flg[4]),
    .two_wire_timeout_flag(tw_to), .keypad_flag(flg[6]), .serial_rx_flag(flg[8]), .serial_tx_flag(tx_f),
    .main_enable_reg(map0(en) | {glob, 7'h0}), .extended_enable_reg(map1(en)),
    .prio_low_group0(map0(lo)), .prio_high_group0(map0(hi)),
    .prio_low_group1(map1(lo)), .prio_high_group1(map1(hi)),
    .vec_call(vec_call), .vec_addr(vec_addr), .ext0_flag(ext0_flag), .ext1_flag(ext1_flag),
    .clr_ext0(clr_ext0), .clr_timer0(clr_timer0), .clr_timer1(clr_timer1), .clr_brownout(clr_brownout),
    .wake_req(wake_req), .active_levels(active_levels), .clr_ext1(clr_ext1));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // watch up to 40 clocks for a vector call; leaves the bench on a falling edge
  task automatic wait_vec(output logic got);
    got = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (vec_call === 1'b1) begin
        got = 1'b1;
        clr_seen = {1'b0, clr_timer1, 1'b0, clr_ext1, 1'b0, clr_timer0, 1'b0, clr_brownout, clr_ext0};
        break;
      end
    end
    @(negedge clk);
  endtask : wait_vec
  // hold the return strobe until one poll has taken it
  task automatic do_reti();
    reti_go = 1'b1;
    do @(posedge clk); while (mc_tick !== 1'b1);
    @(negedge clk);
    reti_go = 1'b0;
  endtask : do_reti
  task automatic expect_vec(input int idx);
    logic got;
    wait_vec(got);
    chk(16'(got), 16'h0001);
    chk(vec_addr, VEC_EXP[idx]);
  endtask : expect_vec
  task automatic expect_none();
    logic got;
    wait_vec(got);
    chk(16'(got), 16'h0000);
  endtask : expect_none
  task automatic t_vectors();
    for (int i = 0; i < 9; i++) begin
      flg = 9'h001 << i;
      en = 9'h001 << i;
      glob = 1'b0;
      expect_none();
      chk(16'(wake_req), 16'(WAKE_EXP[i]));
      chk(16'({ext1_flag, ext0_flag}), 16'({flg[5], flg[0]}));
      glob = 1'b1;
      expect_vec(i);
      chk(16'(clr_seen[i]), 16'(CLR_EXP[i]));
      flg = 9'h0;
      repeat (4) @(negedge clk);
      do_reti();
    end
    $display("test vectors done");
  endtask : t_vectors
  task automatic t_rank();
    lo = 9'h1ff;
    en = 9'h1ff;
    flg = 9'h1ff;
    for (int k = 0; k < 9; k++) begin
      expect_vec(k);
      flg[k] = 1'b0;
      repeat (4) @(negedge clk);
      do_reti();
    end
    $display("test rank done");
  endtask : t_rank
  task automatic t_levels();
    lo = 9'h102;
    hi = 9'h102;
    flg = 9'h101;
    expect_vec(8);
    chk(16'(active_levels), 16'h0008);
    flg[1] = 1'b1;
    expect_none();
    flg[8] = 1'b0;
    do_reti();
    expect_vec(1);
    flg[1] = 1'b0;
    do_reti();
    expect_vec(0);
    flg = 9'h0;
    repeat (4) @(negedge clk);
    do_reti();
    lo = 9'h00c;
    hi = 9'h000;
    flg = 9'h008;
    expect_vec(3);
    flg[2] = 1'b1;
    expect_none();
    lo[2] = 1'b0;
    hi[2] = 1'b1;
    expect_vec(2);
    chk(16'(active_levels), 16'h0006);
    flg = 9'h0;
    do_reti();
    @(negedge clk);
    do_reti();
    chk(16'(active_levels), 16'h0000);
    $display("test levels done");
  endtask : t_levels
  task automatic t_deny();
    lo = 9'h0;
    flg = 9'h080;
    wr_go = 1'b1;
    expect_none();
    wr_go = 1'b0;
    lc_en = 1'b0;
    expect_none();
    reti_go = 1'b1;
    lc_en = 1'b1;
    expect_none();
    reti_go = 1'b0;
    expect_vec(7);
    flg = 9'h0;
    do_reti();
    lc_en = 1'b0;
    flg = 9'h008;
    repeat (12) @(negedge clk);
    flg = 9'h0;
    lc_en = 1'b1;
    expect_none();
    $display("test deny done");
  endtask : t_deny
  // each paired source requests on its second flag alone (two-wire timeout, serial transmit)
  task automatic t_pair();
    tw_to = 1'b1;
    expect_vec(4);
    tw_to = 1'b0;
    tx_f = 1'b1;
    repeat (4) @(negedge clk);
    do_reti();
    expect_vec(8);
    tx_f = 1'b0;
    repeat (4) @(negedge clk);
    do_reti();
    $display("test pair done");
  endtask : t_pair
  task automatic t_edge();
    edge_m = 1'b1;
    repeat (8) @(negedge clk);
    flg[0] = 1'b1;
    expect_vec(0);
    chk(16'(clr_seen[0]), 16'h0001);
    repeat (4) @(negedge clk);
    chk(16'(ext0_flag), 16'h0000);
    do_reti();
    expect_none();
    glob = 1'b0;
    flg[0] = 1'b0;
    repeat (8) @(negedge clk);
    flg[0] = 1'b1;
    repeat (8) @(negedge clk);
    chk(16'(ext0_flag), 16'h0001);
    sw_clr = 1'b1;
    @(negedge clk);
    sw_clr = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(ext0_flag), 16'h0000);
    flg = 9'h0;
    repeat (4) @(negedge clk);
    glob = 1'b1;
    edge_m = 1'b0;
    $display("test edge done");
  endtask : t_edge
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk(vec_addr, 16'h0000);
    t_vectors();
    t_rank();
    t_levels();
    t_deny();
    t_pair();
    t_edge();
    conclude();
  end
endmodule : four_level_interrupt_controller_tb
`default_nettype wire
